// ### logic/otm_timer.sv
// Top: APB registers, prescaler tick, edge detect and master/slave pair
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module otm_timer
   import otm_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire otm_apb_req_t apb_req_i,
   output otm_apb_rsp_t      apb_rsp_o,
   input  wire logic [1:0]   channel_event_input_i,
   output logic [1:0]        channel_interrupt_o,
   output logic [1:0]        channel_enable_status_o,
   output logic              slave_output_pin_o
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic              pwr;
      logic [PRE_W-1:0]  presc;
      logic [PRE_W-1:0]  div;
      logic              tick;
      logic [MODE_W-1:0] mode;
      logic [CNT_W-1:0]  data0;
      logic [CNT_W-1:0]  data1;
      logic [1:0]        sync1;
      logic [1:0]        sync2;
      logic [1:0]        prev;
      logic [1:0]        irq;
      logic [1:0]        ens;
      logic              pin;
      otm_apb_rsp_t      rsp;
   } otm_top_t;

   otm_top_t s;
   otm_top_t next_s;

   logic [CNT_W-1:0] cnt0;
   logic [CNT_W-1:0] cnt1;
   logic [1:0]       ch_irq;
   logic [1:0]       ch_run;
   logic [1:0]       ch_en;
   logic [1:0]       start_p;
   logic [1:0]       stop_p;
   logic [1:0]       trig;
   logic [1:0]       edge_hit;
   logic             acc;
   logic             wr;
   logic             pair;
   logic             ctrl_wr;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic logic reg_mapped(input logic [7:0] a);
      reg_mapped = (a == REG_CTRL)  || (a == REG_PRESC) || (a == REG_START) ||
                   (a == REG_STOP)  || (a == REG_ENST)  || (a == REG_MODE)  ||
                   (a == REG_DATA0) || (a == REG_DATA1) || (a == REG_CNT0)  ||
                   (a == REG_CNT1);
   endfunction

   function automatic logic edge_det(input logic [1:0] sel, input logic now,
                                     input logic old);
      unique case (otm_edge_t'(sel))
         OTM_EDGE_FALL: edge_det = old & ~now;
         OTM_EDGE_RISE: edge_det = ~old & now;
         OTM_EDGE_BOTH: edge_det = old ^ now;
         OTM_EDGE_PROH: edge_det = 1'b0;
      endcase
   endfunction

   assign pair = s.mode[MODE_PAIR];
   assign acc  = apb_req_i.psel & apb_req_i.penable & ~s.rsp.pready;
   assign wr   = apb_req_i.psel & apb_req_i.penable & s.rsp.pready &
                 apb_req_i.pwrite & s.pwr;
   assign ctrl_wr = apb_req_i.psel & apb_req_i.penable & s.rsp.pready &
                    apb_req_i.pwrite & (apb_req_i.paddr == REG_CTRL);

   // ----------------------------------------
   // Triggers
   // ----------------------------------------
   generate
      for (genvar i = 0; i < 2; i++) begin : g_trig
         assign start_p[i] = wr && apb_req_i.paddr == REG_START &&
                             apb_req_i.pwdata[i];
         assign stop_p[i]  = wr && apb_req_i.paddr == REG_STOP &&
                             apb_req_i.pwdata[i];
         assign edge_hit[i] = edge_det(s.mode[MODE_EDGE0 + 2*i +: 2],
                                       s.sync2[i], s.prev[i]);
      end
   endgenerate

   assign trig[0] = edge_hit[0] | (start_p[0] & (ch_en[0] | pair));
   assign trig[1] = pair ? ch_irq[0] : (edge_hit[1] | (start_p[1] & ch_en[1]));

   // ----------------------------------------
   // Channels
   // ----------------------------------------
   // channel 0 is master
   otm_channel u_master (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clear_i (~s.pwr),
      .start_i (start_p[0]),
      .stop_i  (stop_p[0]),
      .trig_i  (trig[0]),
      .tick_i  (s.tick),
      .data_i  (s.data0),
      .count_o (cnt0),
      .irq_o   (ch_irq[0]),
      .run_o   (ch_run[0]),
      .en_o    (ch_en[0])
   );

   otm_channel u_slave (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clear_i (~s.pwr),
      .start_i (start_p[1]),
      .stop_i  (stop_p[1]),
      .trig_i  (trig[1]),
      .tick_i  (s.tick),
      .data_i  (s.data1),
      .count_o (cnt1),
      .irq_o   (ch_irq[1]),
      .run_o   (ch_run[1]),
      .en_o    (ch_en[1])
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_s            = s;
      next_s.rsp.pready = acc;
      next_s.sync1      = channel_event_input_i;
      next_s.sync2      = s.sync1;
      next_s.prev       = s.sync2;
      next_s.irq        = ch_irq;
      next_s.ens        = ch_en;
      next_s.tick       = 1'b0;
      if (s.pwr) begin
         if (s.div >= s.presc) begin
            next_s.div  = '0;
            next_s.tick = 1'b1;
         end else begin
            next_s.div = s.div + 16'h0001;
         end
      end
      next_s.pin = s.mode[MODE_OLVL] ^
                   (pair & s.mode[MODE_OEN] & ch_run[1]);
      if (acc) begin
         next_s.rsp.pslverr = ~reg_mapped(apb_req_i.paddr);
         next_s.rsp.prdata  = 32'h0000_0000;
         unique case (apb_req_i.paddr)
            REG_CTRL:  next_s.rsp.prdata[0] = s.pwr;
            REG_PRESC: next_s.rsp.prdata[PRE_W-1:0] = s.presc;
            REG_START: next_s.rsp.prdata = 32'h0000_0000;
            REG_STOP:  next_s.rsp.prdata = 32'h0000_0000;
            REG_ENST:  next_s.rsp.prdata[1:0] = s.ens;
            REG_MODE:  next_s.rsp.prdata[MODE_W-1:0] = s.mode;
            REG_DATA0: next_s.rsp.prdata[CNT_W-1:0] = s.data0;
            REG_DATA1: next_s.rsp.prdata[CNT_W-1:0] = s.data1;
            REG_CNT0:  next_s.rsp.prdata[CNT_W-1:0] = cnt0;
            REG_CNT1:  next_s.rsp.prdata[CNT_W-1:0] = cnt1;
            default:   next_s.rsp.prdata = 32'h0000_0000;
         endcase
      end else begin
         next_s.rsp.pslverr = 1'b0;
      end
      if (ctrl_wr) begin
         next_s.pwr = apb_req_i.pwdata[0];
      end
      if (wr) begin
         unique case (apb_req_i.paddr)
            REG_PRESC: next_s.presc = apb_req_i.pwdata[PRE_W-1:0];
            REG_MODE:  next_s.mode  = apb_req_i.pwdata[MODE_W-1:0];
            REG_DATA0: next_s.data0 = apb_req_i.pwdata[CNT_W-1:0];
            REG_DATA1: next_s.data1 = apb_req_i.pwdata[CNT_W-1:0];
            default:   next_s.presc = next_s.presc;
         endcase
      end
      if (!s.pwr) begin
         next_s.presc = PRESC_RST;
         next_s.div   = '0;
         next_s.tick  = 1'b0;
         next_s.mode  = MODE_RST;
         next_s.data0 = CNT_ZERO;
         next_s.data1 = CNT_ZERO;
         next_s.irq   = 2'b00;
         next_s.ens   = 2'b00;
         next_s.pin   = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign apb_rsp_o               = s.rsp;
   assign channel_interrupt_o     = s.irq;
   assign channel_enable_status_o = s.ens;
   assign slave_output_pin_o      = s.pin;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Slave armed by master fire, loads at next tick
   logic chk_due;

   always_ff @(posedge clk_i) begin
      if (rst_i || !s.pwr || stop_p[1]) begin
         chk_due <= 1'b0;
      end else if (pair && ch_irq[0] && ch_en[1] && !ch_run[1]) begin
         chk_due <= 1'b1;
      end else if (s.tick) begin
         chk_due <= 1'b0;
      end
   end

   sequence seq_slave_load;
      chk_due && s.tick && !stop_p[1];
   endsequence

   sequence seq_slave_loaded;
      cnt1 == s.data1 || !s.pwr;
   endsequence

   chk_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      !s.pwr |=> s.data0 == CNT_ZERO && s.mode == MODE_RST)
      else $error("write taken while unpowered");
   chk_power_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      !s.pwr ##1 !s.pwr |-> ch_en == 2'b00 && cnt0 == CNT_ZERO)
      else $error("channel survived power-off");
   chk_power_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(s.pwr) |-> ch_en == 2'b00)
      else $error("channel running at power-on");
   chk_trig_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      acc && (apb_req_i.paddr == REG_START || apb_req_i.paddr == REG_STOP)
      |=> s.rsp.prdata == 32'h0000_0000)
      else $error("trigger bit read nonzero");
   for (genvar i = 0; i < 2; i++) begin : g_edge_chk
      chk_edge_prohib: assert property (@(posedge clk_i) disable iff (rst_i)
         s.mode[MODE_EDGE0 + 2*i +: 2] == OTM_EDGE_PROH |-> !edge_hit[i])
         else $error("prohibited edge detected");
   end
   chk_slave_start: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_slave_load |=> seq_slave_loaded)
      else $error("slave not loaded after master");
   chk_slave_out: assert property (@(posedge clk_i) disable iff (rst_i)
      s.pwr ##1 s.pwr |-> s.pin == ($past(s.mode[MODE_OLVL]) ^
      ($past(pair) & $past(s.mode[MODE_OEN]) & $past(ch_run[1]))))
      else $error("slave output wrong");
   chk_tick_one: assert property (@(posedge clk_i) disable iff (rst_i)
      s.tick && s.presc != PRESC_RST |=> !s.tick)
      else $error("tick longer than one cycle");
   // APB answer after one wait
   chk_apb_ready: assert property (@(posedge clk_i) disable iff (rst_i)
      acc |=> s.rsp.pready ##1 !s.rsp.pready)
      else $error("pready not one cycle");

   chk_pulse_start: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_slave_load ##1 ch_run[1] |=> !$past(s.pwr) ||
      s.pin == ($past(s.mode[MODE_OLVL]) ^ ($past(pair) & $past(s.mode[MODE_OEN]))))
      else $error("pulse did not start");

   chk_irq_out: assert property (@(posedge clk_i) disable iff (rst_i)
      s.pwr |=> s.irq == $past(ch_irq))
      else $error("interrupt output lost");

   chk_ens_out: assert property (@(posedge clk_i) disable iff (rst_i)
      s.pwr |=> s.ens == $past(ch_en))
      else $error("enable status lost");

   chk_tick_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !s.pwr |=> !s.tick)
      else $error("tick while unpowered");

   // Unmapped address answers with error
   chk_apb_err: assert property (@(posedge clk_i) disable iff (rst_i)
      acc && !reg_mapped(apb_req_i.paddr) |=> s.rsp.pslverr)
      else $error("unmapped access without error");

   // No answer without an access
   chk_rdy_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !acc |=> !s.rsp.pready)
      else $error("pready without access");

   chk_pwr_read: assert property (@(posedge clk_i) disable iff (rst_i)
      acc && apb_req_i.paddr == REG_CTRL |=> s.rsp.prdata == {31'h0, $past(s.pwr)})
      else $error("power bit read wrong");

   chk_ens_read: assert property (@(posedge clk_i) disable iff (rst_i)
      acc && apb_req_i.paddr == REG_ENST |=> s.rsp.prdata[1:0] == $past(s.ens))
      else $error("enable status read wrong");

   chk_cnt_read: assert property (@(posedge clk_i) disable iff (rst_i)
      acc && apb_req_i.paddr == REG_CNT0 |=> s.rsp.prdata[CNT_W-1:0] == $past(cnt0))
      else $error("count read wrong");

   chk_pin_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !s.pwr |=> !s.pin)
      else $error("output active while unpowered");

   chk_presc_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !s.pwr |=> s.presc == PRESC_RST && s.div == '0)
      else $error("prescaler survived power-off");

   chk_data_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      s.pwr && !wr |=> s.data0 == $past(s.data0) &&
      s.data1 == $past(s.data1))
      else $error("data register changed unwritten");
endmodule

// ### logic/otm_pkg.sv
// Package: register map, fields and carriers of the one-count timer pair
// Functional notes
// - Power enable set: clock unit, accept writes
// - Power enable clear: no clock, writes ignored
// - Power-off returns every channel register to reset
// - Start bit sets enable, reads back zero
// - Valid edge copies data into count
// - Count down per tick, interrupt, hold zero
// - Data writable, count readable while running
// - Stop bit clears enable, count held
// - Master channel pairs with slave channel
// - Delay data plus two, width data
// - Master loads on start, stops at zero
// - Slave starts on master interrupt
// - Slave output active until slave zero
// - Software start bit also starts one-shot
// - Edge select: fall, rise, both, prohibited
// - New data used from next period
// - Trigger to interrupt is data plus one
package otm_pkg;
   localparam int          CNT_W      = 16;
   localparam int          PRE_W      = 16;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_PRESC  = 8'h04;
   localparam logic [7:0]  REG_START  = 8'h08;
   localparam logic [7:0]  REG_STOP   = 8'h0c;
   localparam logic [7:0]  REG_ENST   = 8'h10;
   localparam logic [7:0]  REG_MODE   = 8'h14;
   localparam logic [7:0]  REG_DATA0  = 8'h18;
   localparam logic [7:0]  REG_DATA1  = 8'h1c;
   localparam logic [7:0]  REG_CNT0   = 8'h20;
   localparam logic [7:0]  REG_CNT1   = 8'h24;
   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int          MODE_PAIR  = 0;
   localparam int          MODE_EDGE0 = 1;
   localparam int          MODE_EDGE1 = 3;
   localparam int          MODE_OLVL  = 5;
   localparam int          MODE_OEN   = 6;
   localparam int          MODE_W     = 7;
   localparam logic [MODE_W-1:0] MODE_RST  = 7'h00;
   localparam logic [PRE_W-1:0]  PRESC_RST = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;

   typedef enum logic [1:0] {
      OTM_EDGE_FALL = 2'h0,
      OTM_EDGE_RISE = 2'h1,
      OTM_EDGE_BOTH = 2'h2,
      OTM_EDGE_PROH = 2'h3
   } otm_edge_t;

   typedef enum logic [2:0] {
      OTM_IDLE = 3'b001,
      OTM_WAIT = 3'b010,
      OTM_RUN  = 3'b100
   } otm_chst_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } otm_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } otm_apb_rsp_t;
endpackage

// ### logic/otm_channel.sv
// One-count down-counter channel with trigger wait and hold at zero
`timescale 1ns/1ns
module otm_channel
   import otm_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             clear_i,
   input  wire logic             start_i,
   input  wire logic             stop_i,
   input  wire logic             trig_i,
   input  wire logic             tick_i,
   input  wire logic [CNT_W-1:0] data_i,
   output logic      [CNT_W-1:0] count_o,
   output logic                  irq_o,
   output logic                  run_o,
   output logic                  en_o
);
   typedef struct packed {
      otm_chst_t        st;
      logic             pend;
      logic [CNT_W-1:0] cnt;
      logic             irq;
   } otm_ch_t;

   otm_ch_t s;
   otm_ch_t next_s;

   always_comb begin
      next_s     = s;
      next_s.irq = 1'b0;
      if (stop_i) begin
         next_s.st   = OTM_IDLE;
         next_s.pend = 1'b0;
      end else begin
         if (start_i && s.st == OTM_IDLE) begin
            next_s.st = OTM_WAIT;
         end
         // Triggers during a run are ignored
         if (trig_i && s.st == OTM_WAIT) begin
            next_s.pend = 1'b1;
         end
         if (tick_i && s.st == OTM_WAIT && s.pend) begin
            next_s.cnt  = data_i;
            next_s.pend = 1'b0;
            if (data_i == CNT_ZERO) begin
               next_s.irq = 1'b1;
            end else begin
               next_s.st = OTM_RUN;
            end
         end else if (tick_i && s.st == OTM_RUN) begin
            next_s.cnt = s.cnt - CNT_ONE;
            if (s.cnt == CNT_ONE) begin
               next_s.irq = 1'b1;
               next_s.st  = OTM_WAIT;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         s <= '{st: OTM_IDLE, pend: 1'b0, cnt: CNT_ZERO, irq: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign count_o = s.cnt;
   assign irq_o   = s.irq;
   assign run_o   = (s.st == OTM_RUN);
   assign en_o    = (s.st != OTM_IDLE);

   chk_load_data: assert property (@(posedge clk_i) disable iff (rst_i || clear_i)
      tick_i && s.st == OTM_WAIT && s.pend && !stop_i |=> s.cnt == $past(data_i))
      else $error("count not loaded from data");
   chk_irq_zero: assert property (@(posedge clk_i) disable iff (rst_i || clear_i)
      s.irq |-> s.cnt == CNT_ZERO && s.st != OTM_RUN)
      else $error("interrupt away from zero");
   chk_stop_hold: assert property (@(posedge clk_i) disable iff (rst_i || clear_i)
      s.st == OTM_IDLE && !start_i |=> s.cnt == $past(s.cnt) && !s.irq)
      else $error("stopped channel moved");
   chk_tick_gate: assert property (@(posedge clk_i) disable iff (rst_i || clear_i)
      !tick_i |=> s.cnt == $past(s.cnt))
      else $error("count moved without tick");
endmodule

// ### testbench/otm_event_src.sv
// Event pin model driving the two event inputs with a settable lag
`timescale 1ns/1ns
module otm_event_src (
   input  wire logic       clk_i,
   input  wire logic [1:0] want_i,
   input  wire logic [3:0] lag_i,
   output logic      [1:0] pin_o
);
   logic [3:0] wait_cnt;

   initial begin
      pin_o    = 2'h0;
      wait_cnt = 4'h0;
   end

   // Lag lets the pin answer promptly or slowly
   always @(posedge clk_i) begin
      if (want_i == pin_o) begin
         wait_cnt <= 4'h0;
      end else if (wait_cnt >= lag_i) begin
         pin_o <= want_i;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule

// ### testbench/test_one_count_delay_and_one_shot_timer.sv
// Self-checking bench for the one-count timer pair
`timescale 1ns/1ns
module test_one_count_delay_and_one_shot_timer;
   import otm_pkg::*;
   logic         clk_i;
   logic         rst_i;
   otm_apb_req_t req;
   otm_apb_rsp_t rsp;
   logic [1:0]   want;
   logic [3:0]   lag;
   logic [1:0]   pin;
   logic [1:0]   irq;
   logic [1:0]   en_st;
   logic         pulse;
   logic [3:0]   ev;
   logic [31:0]  rd;
   logic         err;
   int           errors;
   int           num_checks;
   int           cyc;
   int           base;
   int           c;
   int           w;
   int           d;
   int           p;
   int           n0;
   int           n1;

   otm_timer DUT (
      .clk_i                   (clk_i),
      .rst_i                   (rst_i),
      .apb_req_i               (req),
      .apb_rsp_o               (rsp),
      .channel_event_input_i   (pin),
      .channel_interrupt_o     (irq),
      .channel_enable_status_o (en_st),
      .slave_output_pin_o      (pulse)
   );

   otm_event_src PIN (
      .clk_i  (clk_i),
      .want_i (want),
      .lag_i  (lag),
      .pin_o  (pin)
   );

   assign ev = {~pulse, pulse, irq};

   always #20 clk_i = ~clk_i;

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
   end

   // ----------------------------------------
   // Compare and bus tasks
   // ----------------------------------------
   task automatic chk_word(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic chk_num(input string nm, input int ex, input int got);
      num_checks++;
      if (got != ex) begin
         errors++;
         $display("Error %s expected %0d seen %0d", nm, ex, got);
      end
   endtask

   // Expected pulse width in clocks for a prescaler value
   function automatic int exp_width(input int data, input int presc);
      return data * (presc + 1);
   endfunction

   // Interrupts for one rise and one fall per edge select
   function automatic int exp_edge_irqs(input int sel);
      case (sel)
         0: return 1;
         1: return 1;
         2: return 2;
         default: return 0;
      endcase
   endfunction

   // Request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k;
      @(posedge clk_i);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clk_i);
      req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (rsp.pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         errors++;
         $display("Error pready expected 1 seen 0");
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask

   // Events: 0,1 interrupts, 2 output high, 3 output low
   task automatic wait_for(input int what);
      int k;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ev[what] !== 1'b1 && k < 3000);
      if (k >= 3000) begin
         errors++;
         $display("Error event %0d expected 1 seen 0", what);
      end
   endtask

   task automatic count_irq(input int len);
      repeat (len) begin
         @(posedge clk_i);
         n0 += int'(irq[0] === 1'b1);
         n1 += int'(irq[1] === 1'b1);
      end
   endtask

   // Delay run; a data value written mid-count must wait a period
   task automatic trig_run(input int dv, input int nv, output int cnt);
      int s;
      if (dv >= 0) begin
         apb(1'b1, REG_DATA0, dv);
      end
      apb(1'b1, REG_START, 32'h1);
      s = cyc;
      if (nv >= 0) begin
         apb(1'b1, REG_DATA0, nv);
         apb(1'b0, REG_CNT0, 32'h0);
         chk_num("count mid run", 1, int'(rd > 0 && rd <= dv));
      end
      wait_for(0);
      cnt = cyc - s;
   endtask

   task automatic shot(input int d0, input int d1, input bit by_pin, output int dl, output int wd);
      int s;
      apb(1'b1, REG_DATA0, d0);
      apb(1'b1, REG_DATA1, d1);
      if (by_pin) begin
         want <= 2'b01;
      end else begin
         apb(1'b1, REG_START, 32'h1);
      end
      s = cyc;
      wait_for(2);
      dl = cyc - s;
      s = cyc;
      wait_for(3);
      wd = cyc - s;
      want <= 2'b00;
      repeat (8) @(posedge clk_i);
   endtask

   task automatic report_and_stop;
      $display("Checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Watchdog, generous for the whole sequence
   // ----------------------------------------
   initial begin
      repeat (30000) @(posedge clk_i);
      errors++;
      report_and_stop();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      req = '0;
      want = 2'h0;
      lag = 4'h0;
      errors = 0;
      num_checks = 0;
      cyc = 0;
      p = $urandom(32'hd2b4);
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      apb(1'b1, REG_DATA0, 32'h1234);
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b0, REG_DATA0, 32'h0);
      chk_word("data while off", 32'h0, rd);
      d = $urandom_range(1, 16'hffff);
      apb(1'b1, REG_DATA0, d);
      apb(1'b0, REG_DATA0, 32'h0);
      chk_word("data when on", d, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk_word("unmapped error", 32'h1, {31'h0, err});
      apb(1'b1, REG_MODE, 32'h0);
      apb(1'b1, REG_START, 32'h1);
      apb(1'b0, REG_START, 32'h0);
      chk_word("start readback", 32'h0, rd);
      chk_word("enable on", 32'h1, {31'h0, en_st[0]});
      trig_run(0, -1, base);
      d = $urandom_range(1, 40);
      trig_run(d, -1, c);
      chk_num("delay period", d, c - base);
      apb(1'b0, REG_CNT0, 32'h0);
      chk_word("count at zero", 32'h0, rd);
      n0 = 0;
      count_irq(40);
      chk_num("irq after hold", 0, n0);
      trig_run(30, 5, c);
      chk_num("old data period", 30, c - base);
      trig_run(-1, -1, c);
      chk_num("new data period", 5, c - base);
      apb(1'b1, REG_DATA0, 32'd60);
      apb(1'b1, REG_START, 32'h1);
      repeat (5) @(posedge clk_i);
      apb(1'b1, REG_STOP, 32'h1);
      apb(1'b0, REG_CNT0, 32'h0);
      w = rd;
      n0 = 0;
      count_irq(80);
      apb(1'b0, REG_CNT0, 32'h0);
      chk_word("count held", w, rd);
      chk_num("irq after stop", 0, n0);
      chk_word("enable off", 32'h0, {31'h0, en_st[0]});
      apb(1'b0, REG_STOP, 32'h0);
      chk_word("stop readback", 32'h0, rd);
      for (int e = 0; e < 4; e++) begin
         apb(1'b1, REG_MODE, e << 3);
         apb(1'b1, REG_DATA1, 32'h3);
         apb(1'b1, REG_START, 32'h2);
         lag <= 4'($urandom_range(0, 9));
         n1 = 0;
         want <= 2'b10;
         count_irq(40);
         want <= 2'b00;
         count_irq(40);
         chk_num("edge select irqs", exp_edge_irqs(e), n1);
         apb(1'b1, REG_STOP, 32'h2);
      end
      lag <= 4'h0;
      apb(1'b1, REG_MODE, 32'h43);
      apb(1'b1, REG_START, 32'h3);
      shot(0, 4, 1'b0, base, w);
      d = $urandom_range(0, 20);
      c = $urandom_range(1, 20);
      shot(d, c, 1'b0, n0, w);
      chk_num("shot delay", d, n0 - base);
      chk_num("shot width", c, w);
      p = $urandom_range(1, 3);
      apb(1'b1, REG_PRESC, p);
      c = $urandom_range(1, 20);
      shot($urandom_range(0, 9), c, 1'b1, n0, w);
      chk_num("pin shot width", exp_width(c, p), w);
      apb(1'b1, REG_CTRL, 32'h0);
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b0, REG_MODE, 32'h0);
      chk_word("mode after off", 32'h0, rd);
      apb(1'b0, REG_DATA1, 32'h0);
      chk_word("data after off", 32'h0, rd);
      chk_word("enables after off", 32'h0, {30'h0, en_st});
      report_and_stop();
   end
endmodule
